// ---- design/sleep_gate_ctrl.sv ----
// deep-sleep clock gating and soft reset controller with avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
module sleep_gate_ctrl
  import sleep_gate_pkg::*;
#(
  parameter int unsigned PORTS = PORT_N   // number of gated ports
) (
  input  wire logic              clk,             // system clock, 100 MHz
  input  wire logic              nrst,            // async reset, active low
  input  wire logic              ce,              // clock enable, freezes state when low
  input  wire logic [ADDR_W-1:0] avs_address,     // byte address
  input  wire logic              avs_read,        // read request
  input  wire logic              avs_write,       // write request
  input  wire logic [DATA_W-1:0] avs_writedata,   // write data
  input  wire logic [3:0]        avs_byteenable,  // byte lanes
  output var  logic [DATA_W-1:0] avs_readdata,    // read data
  output var  logic              avs_waitrequest, // stall
  output var  logic [1:0]        avs_response,    // 00 okay, 10 slave error
  input  wire logic [2:0]        mode_pin,        // power mode from the core, one-hot
  input  wire logic [DATA_W-1:0] dev_caps_one,    // capability mask for soft reset
  input  wire logic              port_req_valid,  // access to a gated port
  input  wire logic [PORTS-1:0]  port_req_sel,    // which port is addressed
  output var  logic              port_fault,      // bus fault pulse for that access
  output var  logic              port_grant,      // access allowed pulse
  output var  logic [PORTS-1:0]  port_clk_en,     // registered effective enables
  output logic      [PORTS-1:0]  port_gclk,       // gated port clocks
  output var  logic              pwm_rst,         // pwm reset, active high
  output var  logic              wdt_rst          // watchdog reset, active high
);
  logic [DATA_W-1:0] soft_rst_q;
  logic [DATA_W-1:0] run_cfg_q;
  logic [DATA_W-1:0] run_gate_q;
  logic [DATA_W-1:0] sleep_gate_q;
  logic [DATA_W-1:0] deep_gate_q;
  logic [2:0]        mode_m_q;
  logic [2:0]        mode_q;
  logic              ack_q;
  logic [PORTS-1:0]  en_reg;
  port_req_s         preq;

  // byte lane expansion for partial writes
  wire [DATA_W-1:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // address decode
  wire hit_rst   = (avs_address == OFS_SOFT_RST0);
  wire hit_cfg   = (avs_address == OFS_RUN_CFG);
  wire hit_run   = (avs_address == OFS_RUN_GATE2);
  wire hit_sleep = (avs_address == OFS_SLEEP_GATE2);
  wire hit_deep  = (avs_address == OFS_DEEP_GATE2);
  wire hit_stat  = (avs_address == OFS_STATUS);
  wire hit_any   = hit_rst | hit_cfg | hit_run | hit_sleep | hit_deep | hit_stat;
  wire req       = (avs_read | avs_write) & ~ack_q;
  wire wr        = avs_write & ack_q & ce;  // lands only at the edge that sees waitrequest low

  // write merges with byte lanes, writable field masks
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] mask);
    merge = (old_v & ~(be_mask & mask)) | (avs_writedata & be_mask & mask);
  endfunction : merge

  wire [DATA_W-1:0] rst_wmask = SOFT_RST_MASK & dev_caps_one;

  // effective gate set from mode and auto gating
  wire       auto_gate = run_cfg_q[BIT_AUTO_GATE];
  wire       in_deep   = (mode_q == MODE_DEEP);
  wire       in_sleep  = (mode_q == MODE_SLEEP);
  wire [DATA_W-1:0] eff_gate = !auto_gate ? run_gate_q :
                               in_deep    ? deep_gate_q :
                               in_sleep   ? sleep_gate_q : run_gate_q;

  // read mux, unused bits zero
  wire [DATA_W-1:0] rd_mux =
    hit_rst   ? (soft_rst_q & SOFT_RST_MASK) :
    hit_cfg   ? (run_cfg_q & RUN_CFG_MASK) :
    hit_run   ? (run_gate_q & GATE_MASK) :
    hit_sleep ? (sleep_gate_q & GATE_MASK) :
    hit_deep  ? (deep_gate_q & GATE_MASK) :
    hit_stat  ? {{(DATA_W-PORTS){1'b0}}, en_reg} : FAULT_DATA;

  assign preq.valid = port_req_valid;
  assign preq.sel   = port_req_sel;
  wire   gated_hit  = |(preq.sel & ~en_reg);

  // power mode pins come from another domain: two flops first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_m_q <= MODE_RUN;
      mode_q   <= MODE_RUN;
    end else if (ce) begin
      mode_m_q <= mode_pin;
      mode_q   <= mode_m_q;
    end
  end

  // soft reset register; only capable bits change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_rst_q <= RESET_VALUE;
    end else if (wr && hit_rst) begin
      soft_rst_q <= merge(soft_rst_q, rst_wmask);
    end
  end

  // run mode clock configuration, auto gating bit only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_cfg_q <= RESET_VALUE;
    end else if (wr && hit_cfg) begin
      run_cfg_q <= merge(run_cfg_q, RUN_CFG_MASK);
    end
  end

  // run and sleep gate sets
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_gate_q   <= RESET_VALUE;
      sleep_gate_q <= RESET_VALUE;
    end else if (wr) begin
      if (hit_run) run_gate_q <= merge(run_gate_q, GATE_MASK);
      if (hit_sleep) sleep_gate_q <= merge(sleep_gate_q, GATE_MASK);
    end
  end

  // deep-sleep gate set, all ports off at reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deep_gate_q <= RESET_VALUE;
    end else if (wr && hit_deep) begin
      deep_gate_q <= merge(deep_gate_q, GATE_MASK);
    end
  end

  // avalon answer: one wait cycle, then ack; unmapped addresses error
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q        <= 1'b0;
      avs_readdata <= RESET_VALUE;
      avs_response <= 2'b00;
    end else if (ce) begin
      ack_q        <= req;
      avs_readdata <= (req && avs_read) ? rd_mux : FAULT_DATA;
      avs_response <= (req && !hit_any) ? 2'b10 : 2'b00;
    end
  end

  // waitrequest low only in the ack cycle; registered from ack next value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= ~req;
    end
  end

  // port access check: fault when its clock is off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_fault <= 1'b0;
      port_grant <= 1'b0;
    end else if (ce) begin
      port_fault <= preq.valid & gated_hit;
      port_grant <= preq.valid & ~gated_hit;
    end
  end

  // unit resets follow the register bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_rst <= 1'b0;
      wdt_rst <= 1'b0;
    end else if (ce) begin
      pwm_rst <= soft_rst_q[BIT_PWM_RST];
      wdt_rst <= soft_rst_q[BIT_WDT_RST];
    end
  end

  assign port_clk_en = en_reg;

  // one glitch-free gate per port
  for (genvar i = 0; i < PORTS; i++) begin : g_gate
    gate_cell u_gate (
      .clk  (clk),
      .nrst (nrst),
      .ce   (ce),
      .en   (eff_gate[i]),
      .en_q (en_reg[i]),
      .gclk (port_gclk[i])
    );
  end
endmodule : sleep_gate_ctrl
`default_nettype wire

// ---- design/sleep_gate_pkg.sv ----
// constants, field layouts and carrier types for the deep-sleep gating and soft reset block
package sleep_gate_pkg;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned PORT_N         = 5;
  localparam logic [11:0] OFS_SOFT_RST0  = 12'h040;
  localparam logic [11:0] OFS_RUN_CFG    = 12'h060;
  localparam logic [11:0] OFS_RUN_GATE2  = 12'h108;
  localparam logic [11:0] OFS_SLEEP_GATE2 = 12'h118;
  localparam logic [11:0] OFS_DEEP_GATE2 = 12'h128;
  localparam logic [11:0] OFS_STATUS     = 12'h200;
  localparam int unsigned BIT_PWM_RST    = 20;
  localparam int unsigned BIT_WDT_RST    = 3;
  localparam int unsigned BIT_AUTO_GATE  = 27;
  localparam logic [31:0] SOFT_RST_MASK  = 32'h0010_0008;
  localparam logic [31:0] GATE_MASK      = 32'h0000_001f;
  localparam logic [31:0] RUN_CFG_MASK   = 32'h0800_0000;
  localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
  localparam logic [31:0] FAULT_DATA     = 32'h0000_0000;

  // power mode of the processor as reported to the gating logic
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP  = 3'b100
  } pwr_mode_e;

  // access aimed at one of the gated ports
  typedef struct packed {
    logic                  valid;
    logic [PORT_N-1:0]     sel;
  } port_req_s;

  // unit control outputs
  typedef struct packed {
    logic [PORT_N-1:0] clk_en;
    logic              pwm_rst;
    logic              wdt_rst;
  } unit_ctrl_s;
endpackage : sleep_gate_pkg

// ---- design/gate_cell.sv ----
// glitch-free clock gate cell for one gated port
`timescale 1ns/1ps
`default_nettype none
module gate_cell (
  input  wire logic clk,      // system clock
  input  wire logic nrst,     // async reset, active low
  input  wire logic ce,       // clock enable
  input  wire logic en,       // requested gate enable
  output var  logic en_q,     // registered enable, whole cycles
  output logic      gclk      // gated clock
);
  logic lat_q;

  // enable registered on the rising edge so the decision is per whole cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
    end else if (ce) begin
      en_q <= en;
    end
  end

  // latch-free gate: enable retimed on the low phase keeps pulses whole
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      lat_q <= 1'b0;
    end else begin
      lat_q <= en_q;
    end
  end

  assign gclk = clk & lat_q;
endmodule : gate_cell
`default_nettype wire

// ---- sim/sleep_gate_monitor.sv ----
// concurrent checks on the sleep gate controller ports
`timescale 1ns/1ps
`default_nettype none
module sleep_gate_monitor
  import sleep_gate_pkg::*;
#(
  parameter int unsigned PORTS = PORT_N // gated port count
) (
  input wire logic             clk,             // system clock
  input wire logic             nrst,            // async reset
  input wire logic             ce,              // clock enable
  input wire logic             avs_read,        // read request
  input wire logic             avs_write,       // write request
  input wire logic [DATA_W-1:0] avs_readdata,   // read data
  input wire logic             avs_waitrequest, // stall
  input wire logic [1:0]       avs_response,    // response code
  input wire logic             port_req_valid,  // port access
  input wire logic [PORTS-1:0] port_req_sel,    // addressed port
  input wire logic             port_fault,      // fault pulse
  input wire logic             port_grant,      // grant pulse
  input wire logic [PORTS-1:0] port_clk_en,     // effective enables
  input wire logic             pwm_rst,         // pwm reset
  input wire logic             wdt_rst          // watchdog reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // access to an unclocked port faults, a clocked one is granted
  a_fault_on_gated: assert property (port_req_valid && ce && |(port_req_sel & ~port_clk_en) |=> port_fault) else $error("no fault");
  a_grant_on_clocked: assert property (port_req_valid && ce && !(|(port_req_sel & ~port_clk_en))
    |=> port_grant && !port_fault) else $error("no grant");
  a_idle_no_pulse: assert property (!port_req_valid && ce |=> !port_fault && !port_grant) else $error("stray pulse");
  // one-cycle answer, then stall again
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest) else $error("late answer");
  a_answer_once: assert property (!avs_waitrequest && ce |=> avs_waitrequest) else $error("long answer");
  a_data_quiet: assert property (avs_waitrequest |-> avs_readdata == '0 && avs_response == 2'b00) else $error("data leak");
  // unit resets move only after a register write
  a_pwm_by_write: assert property ($changed(pwm_rst) |-> $past(avs_write, 2)) else $error("pwm moved");
  a_wdt_by_write: assert property ($changed(wdt_rst) |-> $past(avs_write, 2)) else $error("wdt moved");
  c_fault: cover property (port_fault);
  c_grant: cover property (port_grant);
  c_pwm: cover property ($rose(pwm_rst));
endmodule : sleep_gate_monitor
bind sleep_gate_ctrl sleep_gate_monitor #(.PORTS(PORTS)) sleep_gate_monitor_i (.clk(clk), .nrst(nrst), .ce(ce),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .port_req_valid(port_req_valid), .port_req_sel(port_req_sel),
  .port_fault(port_fault), .port_grant(port_grant), .port_clk_en(port_clk_en), .pwm_rst(pwm_rst), .wdt_rst(wdt_rst));
`default_nettype wire

// ---- sim/sleep_gate_ctrl_tb.sv ----
// self-checking bench for the sleep gate controller
`timescale 1ns/1ps
`default_nettype none
module sleep_gate_ctrl_tb;
  import sleep_gate_pkg::*;
  logic clk = 0, nrst = 0, rd_q = 0, wr_q = 0, valid = 0, wait_r, fault, grant, pwm, wdt;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, caps = '1, rdata, r;
  logic [2:0] mode = MODE_RUN;
  logic [1:0] resp, s;
  logic [4:0] sel = '0, clk_en, gclk;
  int fail_count = 0, samples_checked = 0;
  sleep_gate_ctrl sleep_gate_ctrl_i (.clk(clk), .nrst(nrst), .ce(1'b1), .avs_address(addr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .avs_response(resp), .mode_pin(mode), .dev_caps_one(caps),
    .port_req_valid(valid), .port_req_sel(sel), .port_fault(fault), .port_grant(grant),
    .port_clk_en(clk_en), .port_gclk(gclk), .pwm_rst(pwm), .wdt_rst(wdt));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      fail_count++;
    end
  endtask : chk
  // avalon master: hold request until waitrequest sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    addr <= a; wr_q <= wr; rd_q <= !wr; wdata <= d;
    // no own limit: the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (wait_r !== 1'b0);
    r = rdata;
    s = resp;
    rd_q <= 0; wr_q <= 0;
    // one idle edge so the next call never reassigns in this time step
    @(posedge clk);
  endtask : bus
  task automatic mode_chk(input logic [2:0] m, input logic [4:0] exp);
    mode <= m;
    repeat (8) @(posedge clk);
    chk("clk_en", {27'h0, clk_en}, {27'h0, exp});
    // look at the gated clocks in the high phase, then realign to the edge
    #1;
    chk("gclk", {27'h0, gclk}, {27'h0, exp});
    @(posedge clk);
  endtask : mode_chk
  task automatic t_modes;
    logic [4:0] run_set = 5'h05;
    bus(1, OFS_RUN_GATE2, 32'h05);
    bus(0, OFS_SLEEP_GATE2, 0);
    bus(1, OFS_SLEEP_GATE2, (r & ~GATE_MASK) | 32'h0a);
    bus(1, OFS_DEEP_GATE2, 32'hffff_fff3);
    bus(0, OFS_DEEP_GATE2, 0); chk("deep", r, 32'h13);
    mode_chk(MODE_DEEP, 5'h05);
    bus(1, OFS_RUN_CFG, RUN_CFG_MASK);
    mode_chk(MODE_SLEEP, 5'h0a);
    mode_chk(MODE_DEEP, 5'h13);
    mode_chk(MODE_RUN, 5'h05);
    for (int i = 0; i < 5; i++) begin
      valid <= 1; sel <= 5'(1 << i);
      @(posedge clk);
      valid <= 0;
      @(posedge clk);
      chk("fault", {31'h0, fault}, {31'h0, ~run_set[i]});
      chk("grant", {31'h0, grant}, {31'h0, run_set[i]});
    end
    $display("modes and ports done");
  endtask : t_modes
  task automatic t_srst;
    bus(1, OFS_SOFT_RST0, '1); bus(0, OFS_SOFT_RST0, 0); chk("srst", r, SOFT_RST_MASK);
    chk("resets", {30'h0, pwm, wdt}, 32'h3);
    bus(1, OFS_SOFT_RST0, 0); repeat (2) @(posedge clk);
    chk("release", {30'h0, pwm, wdt}, 32'h0);
    caps <= 32'h8; bus(1, OFS_SOFT_RST0, '1); bus(0, OFS_SOFT_RST0, 0); chk("masked", r, 32'h8);
    chk("mres", {30'h0, pwm, wdt}, 32'h1);
    bus(0, 12'h7fc, 0); chk("unmapped", {30'h0, s}, 32'h2);
    $display("soft reset done");
  endtask : t_srst
  task automatic t_reset;
    chk("rst_en", {27'h0, clk_en}, 32'h0);
    chk("rst_units", {30'h0, pwm, wdt}, 32'h0);
    bus(0, OFS_DEEP_GATE2, 0); chk("deep_rst", r, RESET_VALUE);
    valid <= 1; sel <= 5'h01;
    @(posedge clk);
    valid <= 0;
    @(posedge clk);
    chk("rst_fault", {31'h0, fault}, 32'h1);
    $display("reset state done");
  endtask : t_reset
  task automatic end_sim;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_srst();
    end_sim();
  end
endmodule : sleep_gate_ctrl_tb
`default_nettype wire
